/* timer_block_params.svh */
// Register addresses, field positions, reset values and divider counts of the timer block.
`ifndef TIMER_BLOCK_PARAMS_SVH
`define TIMER_BLOCK_PARAMS_SVH

`define ADDR_TIMER_CONTROL_STATUS 8'h88
`define ADDR_TIMER_MODE_SELECT 8'h89
`define ADDR_FIRST_LOW 8'h8A
`define ADDR_SECOND_LOW 8'h8B
`define ADDR_FIRST_HIGH 8'h8C
`define ADDR_SECOND_HIGH 8'h8D
`define ADDR_TIMER_CLOCK_SELECT 8'h8E
`define ADDR_THIRD_CONTROL 8'hC8
`define ADDR_THIRD_RELOAD_LOW 8'hCA
`define ADDR_THIRD_RELOAD_HIGH 8'hCB
`define ADDR_THIRD_LOW 8'hCC
`define ADDR_THIRD_HIGH 8'hCD

`define RESET_BYTE 8'h00

// Control/status register fields.
`define TCS_SECOND_FLAG 7
`define TCS_SECOND_RUN 6
`define TCS_FIRST_FLAG 5
`define TCS_FIRST_RUN 4

// Mode register fields.
`define TMS_SECOND_GATE 7
`define TMS_SECOND_COUNTER 6
`define TMS_SECOND_MODE_HI 5
`define TMS_SECOND_MODE_LO 4
`define TMS_FIRST_GATE 3
`define TMS_FIRST_COUNTER 2
`define TMS_FIRST_MODE_HI 1
`define TMS_FIRST_MODE_LO 0

// Clock select register fields.
`define TCK_THIRD_HIGH_SEL 5
`define TCK_THIRD_LOW_SEL 4
`define TCK_SECOND_SEL 3
`define TCK_FIRST_SEL 2
`define TCK_PRESCALE_HI 1
`define TCK_PRESCALE_LO 0

// Third timer control fields.
`define TTC_HIGH_FLAG 7
`define TTC_LOW_FLAG 6
`define TTC_LOW_IRQ_EN 5
`define TTC_CAPTURE_EN 4
`define TTC_SPLIT 3
`define TTC_RUN 2
`define TTC_EXT_SEL 0

// Divider counts.
`define PRESCALE_LAST 6'd47
`define EXT_DIV_LAST 3'h7

`endif

/* timer_block_pkg.sv */
// Types shared by the timer block: bus request, unit modes and counting step result.
package timer_block_pkg;

   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_bus_req_t;

   typedef enum logic [1:0]
   {
      MODE_13BIT = 2'h0,
      MODE_16BIT = 2'h1,
      MODE_RELOAD8 = 2'h2,
      MODE_SPLIT = 2'h3
   } unit_mode_t;

   typedef enum logic [1:0]
   {
      PRE_DIV12 = 2'h0,
      PRE_DIV4 = 2'h1,
      PRE_DIV48 = 2'h2,
      PRE_EXT8 = 2'h3
   } prescale_t;

   typedef struct packed
   {
      logic ovf;
      logic [7:0] low;
      logic [7:0] high;
   } count_step_t;

endpackage : timer_block_pkg

/* dual_mode_timer_block.sv */
// Two classic counter/timer units and an auto-reload third timer behind a byte register port.
// What this block does
// - Mode 2 counts the low byte; rollover sets the flag and reloads from high byte.
// - The high byte reload value stays untouched by every auto-reload.
// - Run bit enables the timer; with gate set the gate input must also be active.
// - Counter select makes the unit count falling edges of its count pin.
// - Per-unit clock select picks system clock or prescaled clock; ignored when counting.
// - Shared prescale field picks the prescaled clock, one code being external divided.
// - Mode field: 13-bit, 16-bit, 8-bit reload, split or inactive.
// - Split mode: first low byte is an 8-bit counter using first unit controls.
// - Split mode: first high byte is timer only, run by second run, sets second flag.
// - During split the second unit counts no pin edges and sets no flag, still ticks.
// - During split the second unit runs in modes 0 to 2 and stops in mode 3.
// - Third timer control bit 3 picks one 16-bit or two 8-bit reload timers.
// - Third timer clocks from system clock, system/12 or synchronised external/8.
// - Third timer 16-bit rollover loads the reload pair and sets the high flag.
// - Third timer interrupt on overflow, plus low byte rollover when low enable set.
// - In split mode the third run bit gates only the high half.
// - In split mode each half reloads from its own reload byte.
// - Clock select 0 gives system/12 or external/8 according to external select.
// - Third timer high clock select matters only in split mode.
// - Low clock select picks system clock or the external-select source.
// - 13-bit mode keeps eight bits high, five bits low, flag on rollover.
// - 16-bit mode uses all sixteen bits of the two bytes.
// - Count pins are sampled so levels held two clocks are seen.
`timescale 1ns/100ps
`include "timer_block_params.svh"

module dual_mode_timer_block
(
   input wire logic clk,
   input wire logic rst,
   input timer_block_pkg::reg_bus_req_t bus_req,
   output logic [7:0] rdata,
   input wire logic count_pin_a,
   input wire logic count_pin_b,
   input wire logic gate_input_a,
   input wire logic gate_input_b,
   input wire logic gate_a_polarity,
   input wire logic gate_b_polarity,
   input wire logic ext_osc_clk,
   input wire logic first_vector_ack,
   input wire logic second_vector_ack,
   input wire logic third_irq_enable,
   output logic first_unit_irq,
   output logic second_unit_irq,
   output logic third_irq,
   output logic second_unit_tick
);
   import timer_block_pkg::*;

   // One counting step of a basic unit in the given mode.
   function automatic count_step_t unit_step(input unit_mode_t mode, input logic [7:0] low,
                                             input logic [7:0] high);
      count_step_t r;
      logic [12:0] c13;
      logic [15:0] c16;
      begin
         c13 = {high, low[4:0]} + 13'h0001;
         c16 = {high, low} + 16'h0001;
         r = '{ovf: 1'b0, low: low, high: high};
         unique case (mode)
            MODE_13BIT:
            begin
               r.ovf = &{high, low[4:0]};
               r.low = {low[7:5], c13[4:0]};
               r.high = c13[12:5];
            end
            MODE_16BIT:
            begin
               r.ovf = &{high, low};
               r.low = c16[7:0];
               r.high = c16[15:8];
            end
            MODE_RELOAD8:
            begin
               r.ovf = &low;
               r.low = (&low) ? high : (low + 8'h01);
               r.high = high;
            end
            MODE_SPLIT:
            begin
               r.ovf = &low;
               r.low = low + 8'h01;
               r.high = high;
            end
         endcase
         return r;
      end
   endfunction : unit_step

   // One 8-bit reload step of a third timer half.
   function automatic logic [8:0] reload_step(input logic [7:0] value, input logic [7:0] reload);
      begin
         return (&value) ? {1'b1, reload} : {1'b0, value + 8'h01};
      end
   endfunction : reload_step

   logic [7:0] tcs_reg;
   logic [7:0] tcs_next;
   logic [7:0] tms_reg;
   logic [7:0] tck_reg;
   logic [7:0] ttc_reg;
   logic [7:0] ttc_next;
   logic [7:0] first_unit_low_byte_reg;
   logic [7:0] first_unit_low_byte_next;
   logic [7:0] first_unit_high_byte_reg;
   logic [7:0] first_unit_high_byte_next;
   logic [7:0] second_unit_low_byte_reg;
   logic [7:0] second_unit_low_byte_next;
   logic [7:0] second_unit_high_byte_reg;
   logic [7:0] second_unit_high_byte_next;
   logic [7:0] third_timer_low_byte_reg;
   logic [7:0] third_timer_low_byte_next;
   logic [7:0] third_timer_high_byte_reg;
   logic [7:0] third_timer_high_byte_next;
   logic [7:0] third_reload_low_reg;
   logic [7:0] third_reload_high_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rd_value;
   logic tick_reg;
   logic [5:0] pre_cnt_reg;
   logic [2:0] ext_cnt_reg;
   logic [2:0] pin_a_sync_reg;
   logic [2:0] pin_b_sync_reg;
   logic [2:0] ext_sync_reg;

   // Register decode.
   wire wr_tcs = bus_req.wr & (bus_req.addr == `ADDR_TIMER_CONTROL_STATUS);
   wire wr_tms = bus_req.wr & (bus_req.addr == `ADDR_TIMER_MODE_SELECT);
   wire wr_tck = bus_req.wr & (bus_req.addr == `ADDR_TIMER_CLOCK_SELECT);
   wire wr_ttc = bus_req.wr & (bus_req.addr == `ADDR_THIRD_CONTROL);
   wire wr_lo0 = bus_req.wr & (bus_req.addr == `ADDR_FIRST_LOW);
   wire wr_hi0 = bus_req.wr & (bus_req.addr == `ADDR_FIRST_HIGH);
   wire wr_lo1 = bus_req.wr & (bus_req.addr == `ADDR_SECOND_LOW);
   wire wr_hi1 = bus_req.wr & (bus_req.addr == `ADDR_SECOND_HIGH);
   wire wr_t2l = bus_req.wr & (bus_req.addr == `ADDR_THIRD_LOW);
   wire wr_t2h = bus_req.wr & (bus_req.addr == `ADDR_THIRD_HIGH);
   wire wr_rll = bus_req.wr & (bus_req.addr == `ADDR_THIRD_RELOAD_LOW);
   wire wr_rlh = bus_req.wr & (bus_req.addr == `ADDR_THIRD_RELOAD_HIGH);
   wire [7:0] wd = bus_req.wdata;

   // Control fields.
   wire first_unit_run = tcs_reg[`TCS_FIRST_RUN];
   wire second_unit_run = tcs_reg[`TCS_SECOND_RUN];
   wire first_unit_overflow_flag = tcs_reg[`TCS_FIRST_FLAG];
   wire second_unit_overflow_flag = tcs_reg[`TCS_SECOND_FLAG];
   wire first_unit_gate_enable = tms_reg[`TMS_FIRST_GATE];
   wire second_unit_gate_enable = tms_reg[`TMS_SECOND_GATE];
   wire first_unit_counter_select = tms_reg[`TMS_FIRST_COUNTER];
   wire second_unit_counter_select = tms_reg[`TMS_SECOND_COUNTER];
   wire unit_mode_t first_unit_mode_field = unit_mode_t'(tms_reg[`TMS_FIRST_MODE_HI:`TMS_FIRST_MODE_LO]);
   wire unit_mode_t second_unit_mode_field = unit_mode_t'(tms_reg[`TMS_SECOND_MODE_HI:`TMS_SECOND_MODE_LO]);
   wire first_unit_clock_select = tck_reg[`TCK_FIRST_SEL];
   wire second_unit_clock_select = tck_reg[`TCK_SECOND_SEL];
   wire prescale_t prescale_field = prescale_t'(tck_reg[`TCK_PRESCALE_HI:`TCK_PRESCALE_LO]);
   wire third_high_clock_select = tck_reg[`TCK_THIRD_HIGH_SEL];
   wire third_low_clock_select = tck_reg[`TCK_THIRD_LOW_SEL];
   wire third_split_enable = ttc_reg[`TTC_SPLIT];
   wire third_run = ttc_reg[`TTC_RUN];
   wire third_external_clock_select = ttc_reg[`TTC_EXT_SEL];
   wire third_low_interrupt_enable = ttc_reg[`TTC_LOW_IRQ_EN];
   wire third_high_overflow_flag = ttc_reg[`TTC_HIGH_FLAG];
   wire third_low_overflow_flag = ttc_reg[`TTC_LOW_FLAG];

   // Free-running prescaler; one mod-48 count serves all three ratios so their ticks stay aligned.
   wire tick_div4 = (pre_cnt_reg[1:0] == 2'h3);
   wire tick_div12 = (pre_cnt_reg == 6'd11) | (pre_cnt_reg == 6'd23) | (pre_cnt_reg == 6'd35) |
                     (pre_cnt_reg == `PRESCALE_LAST);
   wire tick_div48 = (pre_cnt_reg == `PRESCALE_LAST);

   // External oscillator edges are found on the synchronised copy, never on the first stage.
   wire ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];
   wire tick_ext8 = ext_rise & (ext_cnt_reg == `EXT_DIV_LAST);

   // Prescaled clock for the two basic units.
   wire pre_tick = (prescale_field == PRE_DIV12) ? tick_div12 :
                   (prescale_field == PRE_DIV4) ? tick_div4 :
                   (prescale_field == PRE_DIV48) ? tick_div48 : tick_ext8;

   // Count pin falling edges; a level held two clocks reaches the second stage and is seen.
   wire fall_a = pin_a_sync_reg[2] & ~pin_a_sync_reg[1];
   wire fall_b = pin_b_sync_reg[2] & ~pin_b_sync_reg[1];

   // Gate inputs are compared against their configured active level.
   wire gate_a_active = ~(gate_input_a ^ gate_a_polarity);
   wire gate_b_active = ~(gate_input_b ^ gate_b_polarity);

   // First unit run and clock choice.
   wire split0 = (first_unit_mode_field == MODE_SPLIT);
   wire run0 = first_unit_run & (~first_unit_gate_enable | gate_a_active);
   wire base0 = first_unit_clock_select ? 1'b1 : pre_tick;
   wire clk0 = first_unit_counter_select ? fall_a : base0;
   wire step0 = run0 & clk0;
   wire count_step_t s0 = unit_step(first_unit_mode_field, first_unit_low_byte_reg, first_unit_high_byte_reg);

   // Split high byte: timer only, started by the second run bit.
   wire hi_step = split0 & second_unit_run & base0;
   wire hi_ovf = hi_step & (&first_unit_high_byte_reg);

   // Second unit: while split, run follows its mode field and pin counting is locked out.
   wire run1 = (second_unit_mode_field != MODE_SPLIT) & (split0 | second_unit_run) &
               (~second_unit_gate_enable | gate_b_active);
   wire base1 = second_unit_clock_select ? 1'b1 : pre_tick;
   wire clk1 = (second_unit_counter_select & ~split0) ? fall_b : base1;
   wire step1 = run1 & clk1;
   wire count_step_t s1 = unit_step(second_unit_mode_field, second_unit_low_byte_reg, second_unit_high_byte_reg);
   wire ovf1 = step1 & s1.ovf;

   // Flag sources; a hardware set beats a clear arriving in the same cycle.
   wire set_fl0 = step0 & s0.ovf;
   wire set_fl1 = split0 ? hi_ovf : ovf1;
   wire fl0_next = set_fl0 | (wr_tcs ? wd[`TCS_FIRST_FLAG] :
                   (first_unit_overflow_flag & ~first_vector_ack));
   wire fl1_next = set_fl1 | (wr_tcs ? wd[`TCS_SECOND_FLAG] :
                   (second_unit_overflow_flag & ~second_vector_ack));

   // Control register next value: run and spare bits follow software, flags as above.
   assign tcs_next = {fl1_next, wr_tcs ? wd[6] : tcs_reg[6], fl0_next, wr_tcs ? wd[4:0] : tcs_reg[4:0]};

   // Basic unit byte next values; a software write wins over a count in the same cycle.
   assign first_unit_low_byte_next = wr_lo0 ? wd : (step0 ? s0.low : first_unit_low_byte_reg);
   assign first_unit_high_byte_next = wr_hi0 ? wd :
                                      hi_step ? (first_unit_high_byte_reg + 8'h01) :
                                      step0 ? s0.high : first_unit_high_byte_reg;
   assign second_unit_low_byte_next = wr_lo1 ? wd : (step1 ? s1.low : second_unit_low_byte_reg);
   assign second_unit_high_byte_next = wr_hi1 ? wd : (step1 ? s1.high : second_unit_high_byte_reg);

   // Third timer clock choice.
   wire t2_src = third_external_clock_select ? tick_ext8 : tick_div12;
   wire t2_low_clk = third_low_clock_select ? 1'b1 : t2_src;
   wire t2_high_clk = third_split_enable ? (third_high_clock_select ? 1'b1 : t2_src) : t2_low_clk;
   // Third timer 16-bit step.
   wire t2_step16 = ~third_split_enable & third_run & t2_low_clk;
   wire t2_full = &{third_timer_high_byte_reg, third_timer_low_byte_reg};
   wire [15:0] t2_inc = {third_timer_high_byte_reg, third_timer_low_byte_reg} + 16'h0001;
   wire [15:0] t2_val16 = t2_full ? {third_reload_high_reg, third_reload_low_reg} : t2_inc;
   // Third timer split halves: low runs always, high only with the run bit.
   wire t2_step_lo = third_split_enable & t2_low_clk;
   wire t2_step_hi = third_split_enable & third_run & t2_high_clk;
   wire [8:0] t2_lo8 = reload_step(third_timer_low_byte_reg, third_reload_low_reg);
   wire [8:0] t2_hi8 = reload_step(third_timer_high_byte_reg, third_reload_high_reg);
   // Third timer overflow events.
   wire set_fl2h = (t2_step16 & t2_full) | (t2_step_hi & t2_hi8[8]);
   wire set_fl2l = (t2_step16 & (&third_timer_low_byte_reg)) | (t2_step_lo & t2_lo8[8]);

   assign third_timer_low_byte_next = wr_t2l ? wd :
                                      t2_step16 ? t2_val16[7:0] :
                                      t2_step_lo ? t2_lo8[7:0] : third_timer_low_byte_reg;
   assign third_timer_high_byte_next = wr_t2h ? wd :
                                       t2_step16 ? t2_val16[15:8] :
                                       t2_step_hi ? t2_hi8[7:0] : third_timer_high_byte_reg;

   // Third control: flags only ever cleared by software writes, and a set wins over that write.
   assign ttc_next = {set_fl2h | (wr_ttc ? wd[7] : ttc_reg[7]),
                      set_fl2l | (wr_ttc ? wd[6] : ttc_reg[6]),
                      wr_ttc ? wd[5:2] : ttc_reg[5:2],
                      1'b0,
                      wr_ttc ? wd[0] : ttc_reg[0]};

   // Read selection; unmapped addresses read as zero.
   always_comb
   begin
      unique case (bus_req.addr)
         `ADDR_TIMER_CONTROL_STATUS: rd_value = tcs_reg;
         `ADDR_TIMER_MODE_SELECT: rd_value = tms_reg;
         `ADDR_TIMER_CLOCK_SELECT: rd_value = tck_reg;
         `ADDR_FIRST_LOW: rd_value = first_unit_low_byte_reg;
         `ADDR_FIRST_HIGH: rd_value = first_unit_high_byte_reg;
         `ADDR_SECOND_LOW: rd_value = second_unit_low_byte_reg;
         `ADDR_SECOND_HIGH: rd_value = second_unit_high_byte_reg;
         `ADDR_THIRD_CONTROL: rd_value = ttc_reg;
         `ADDR_THIRD_RELOAD_LOW: rd_value = third_reload_low_reg;
         `ADDR_THIRD_RELOAD_HIGH: rd_value = third_reload_high_reg;
         `ADDR_THIRD_LOW: rd_value = third_timer_low_byte_reg;
         `ADDR_THIRD_HIGH: rd_value = third_timer_high_byte_reg;
         default: rd_value = 8'h00;
      endcase
   end

   // Dividers and input samplers.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pre_cnt_reg <= 6'h00;
         ext_cnt_reg <= 3'h0;
         pin_a_sync_reg <= 3'h7;
         pin_b_sync_reg <= 3'h7;
         ext_sync_reg <= 3'h0;
      end
      else
      begin
         pre_cnt_reg <= (pre_cnt_reg == `PRESCALE_LAST) ? 6'h00 : (pre_cnt_reg + 6'h01);
         ext_cnt_reg <= ext_rise ? (ext_cnt_reg + 3'h1) : ext_cnt_reg;
         pin_a_sync_reg <= {pin_a_sync_reg[1:0], count_pin_a};
         pin_b_sync_reg <= {pin_b_sync_reg[1:0], count_pin_b};
         ext_sync_reg <= {ext_sync_reg[1:0], ext_osc_clk};
      end
   end

   // Configuration and reload registers.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tcs_reg <= `RESET_BYTE;
         tms_reg <= `RESET_BYTE;
         tck_reg <= `RESET_BYTE;
         ttc_reg <= `RESET_BYTE;
         third_reload_low_reg <= `RESET_BYTE;
         third_reload_high_reg <= `RESET_BYTE;
      end
      else
      begin
         tcs_reg <= tcs_next;
         tms_reg <= wr_tms ? wd : tms_reg;
         tck_reg <= wr_tck ? wd : tck_reg;
         ttc_reg <= ttc_next;
         third_reload_low_reg <= wr_rll ? wd : third_reload_low_reg;
         third_reload_high_reg <= wr_rlh ? wd : third_reload_high_reg;
      end
   end

   // Count registers, read data and the second unit's overflow tick.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         first_unit_low_byte_reg <= `RESET_BYTE;
         first_unit_high_byte_reg <= `RESET_BYTE;
         second_unit_low_byte_reg <= `RESET_BYTE;
         second_unit_high_byte_reg <= `RESET_BYTE;
         third_timer_low_byte_reg <= `RESET_BYTE;
         third_timer_high_byte_reg <= `RESET_BYTE;
         rdata_reg <= 8'h00;
         tick_reg <= 1'b0;
      end
      else
      begin
         first_unit_low_byte_reg <= first_unit_low_byte_next;
         first_unit_high_byte_reg <= first_unit_high_byte_next;
         second_unit_low_byte_reg <= second_unit_low_byte_next;
         second_unit_high_byte_reg <= second_unit_high_byte_next;
         third_timer_low_byte_reg <= third_timer_low_byte_next;
         third_timer_high_byte_reg <= third_timer_high_byte_next;
         rdata_reg <= bus_req.rd ? rd_value : 8'h00;
         tick_reg <= ovf1;
      end
   end

   // Interrupt requests are levels taken from the flag registers; the third is masked by third_irq_enable, and its low flag also by the low enable.
   assign rdata = rdata_reg;
   assign second_unit_tick = tick_reg;
   assign first_unit_irq = first_unit_overflow_flag;
   assign second_unit_irq = second_unit_overflow_flag;
   assign third_irq = third_irq_enable & (third_high_overflow_flag |
                      (third_low_interrupt_enable & third_low_overflow_flag));

endmodule : dual_mode_timer_block

/* timer_block_properties.sv */
// Concurrent checks on the ports of the dual mode timer block.
`timescale 1ns/100ps
module timer_block_properties
(
   input wire logic clk,
   input wire logic rst,
   input timer_block_pkg::reg_bus_req_t bus_req,
   input wire logic [7:0] rdata,
   input wire logic first_vector_ack,
   input wire logic second_vector_ack,
   input wire logic third_irq_enable,
   input wire logic first_unit_irq,
   input wire logic second_unit_irq,
   input wire logic third_irq
);
   import timer_block_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Decoded strobes for the registers the checks care about.
   wire wr_tcs = bus_req.wr && bus_req.addr == 8'h88;
   wire wr_mode = bus_req.wr && bus_req.addr == 8'h89;
   wire wr_ttc = bus_req.wr && bus_req.addr == 8'hC8;
   wire rd_mode = bus_req.rd && bus_req.addr == 8'h89;
   wire rd_ttc = bus_req.rd && bus_req.addr == 8'hC8;
   // A write followed, one idle cycle later, by a read of the same register.
   sequence mode_wr_rd;
      wr_mode ##2 rd_mode;
   endsequence
   sequence ttc_wr_rd;
      wr_ttc ##2 rd_ttc;
   endsequence
   mode_readback_a: assert property (mode_wr_rd |=> rdata == $past(bus_req.wdata, 3))
      else $error("mode register read back differs from write");
   split_readback_a: assert property (ttc_wr_rd |=> rdata[3] == $past(bus_req.wdata[3], 3) && !rdata[1])
      else $error("third control read back differs from write");
   first_flag_hold_a: assert property (first_unit_irq && !first_vector_ack && !wr_tcs |=> first_unit_irq)
      else $error("first unit flag dropped without a clear");
   second_flag_hold_a: assert property (second_unit_irq && !second_vector_ack && !wr_tcs |=>
      second_unit_irq)
      else $error("second unit flag dropped without a clear");
   first_soft_set_a: assert property (wr_tcs && bus_req.wdata[5] |=> first_unit_irq)
      else $error("first unit flag not set by a write of one");
   third_flag_hold_a: assert property (third_irq && !wr_ttc |=> third_irq || !third_irq_enable)
      else $error("third timer request dropped without software");
   third_mask_a: assert property (!third_irq_enable |-> !third_irq)
      else $error("third timer request while disabled");
   third_soft_set_a: assert property (wr_ttc && bus_req.wdata[7] ##1 third_irq_enable |-> third_irq)
      else $error("third timer high flag gives no request");
endmodule : timer_block_properties

bind dual_mode_timer_block timer_block_properties timer_block_properties_i
(
   .clk(clk),
   .rst(rst),
   .bus_req(bus_req),
   .rdata(rdata),
   .first_vector_ack(first_vector_ack),
   .second_vector_ack(second_vector_ack),
   .third_irq_enable(third_irq_enable),
   .first_unit_irq(first_unit_irq),
   .second_unit_irq(second_unit_irq),
   .third_irq(third_irq)
);

/* count_pin_model.sv */
// Model of the external event source that drives a count pin.
`timescale 1ns/100ps
module count_pin_model
(
   input wire logic clk,
   output logic pin
);
   // The pin idles high, as a pulled-up input would.
   initial pin = 1'b1;
   // Each level is held beyond two clocks so the sampler cannot miss it.
   task automatic pulses(input int n);
      repeat (n)
      begin
         @(posedge clk);
         pin <= 1'b0;
         repeat (3) @(posedge clk);
         pin <= 1'b1;
         repeat (3) @(posedge clk);
      end
   endtask : pulses
endmodule : count_pin_model

/* tb.sv */
// Self-checking bench for the dual mode timer block.
`timescale 1ns/100ps
module tb;
   import timer_block_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   reg_bus_req_t bus_req = '0;
   logic [7:0] rdata;
   logic count_pin_a;
   logic gate_input_a = 1'b0;
   logic ext_osc_clk = 1'b0;
   logic first_vector_ack = 1'b0;
   logic second_vector_ack = 1'b0;
   logic third_irq_enable = 1'b0;
   logic first_unit_irq;
   logic second_unit_irq;
   logic third_irq;
   logic second_unit_tick;
   integer fail_count = 0;
   integer check_count = 0;
   // System clock and an unrelated external oscillator.
   always #2.5 clk = ~clk;
   always #7 ext_osc_clk = ~ext_osc_clk;
   dual_mode_timer_block dual_mode_timer_block_i (.clk(clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
      .count_pin_a(count_pin_a), .count_pin_b(1'b1), .gate_input_a(gate_input_a), .gate_input_b(1'b0),
      .gate_a_polarity(1'b1), .gate_b_polarity(1'b1), .ext_osc_clk(ext_osc_clk),
      .first_vector_ack(first_vector_ack), .second_vector_ack(second_vector_ack),
      .third_irq_enable(third_irq_enable), .first_unit_irq(first_unit_irq),
      .second_unit_irq(second_unit_irq), .third_irq(third_irq), .second_unit_tick(second_unit_tick));
   count_pin_model count_pin_model_i (.clk(clk), .pin(count_pin_a));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // One bus cycle; the read data are taken in the cycle after the strobe.
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] v);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk);
      bus_req <= '0;
      #1 v = rdata;
   endtask : acc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] x;
      acc(1'b1, a, d, x);
   endtask : wr
   task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      acc(1'b0, a, 8'h00, v);
      chk(n, e, v);
   endtask : rchk
   // Bounded wait; a hang is reported and ends the run.
   task automatic wait_sig(input string n, ref logic s, input int lim);
      for (int i = 0; i < lim && s !== 1'b1; i++)
         @(posedge clk) #1;
      chk(n, 8'h01, {7'h00, s});
      if (s !== 1'b1)
         end_sim();
   endtask : wait_sig
   task automatic pulse_ack(input logic s);
      @(posedge clk);
      first_vector_ack <= !s;
      second_vector_ack <= s;
      @(posedge clk);
      first_vector_ack <= 1'b0;
      second_vector_ack <= 1'b0;
      #1;
   endtask : pulse_ack
   task automatic reg_rw;
      logic [7:0] a[4] = '{8'h88, 8'h89, 8'h8E, 8'hC8};
      for (int k = 0; k < 4; k++)
         rchk("reset value", a[k], 8'h00);
      rchk("unmapped", 8'h00, 8'h00);
      wr(8'h88, 8'hAF);
      rchk("control", 8'h88, 8'hAF);
      pulse_ack(1'b1);
      chk("second ack", 8'h00, {7'h00, second_unit_irq});
      wr(8'h89, 8'h5A);
      rchk("mode", 8'h89, 8'h5A);
      third_irq_enable <= 1'b1;
      wr(8'hC8, 8'h8B);
      rchk("third control", 8'hC8, 8'h89);
      chk("third request", 8'h01, {7'h00, third_irq});
      wr(8'h88, 8'h00);
      wr(8'h89, 8'h00);
      wr(8'hC8, 8'h00);
   endtask : reg_rw
   task automatic auto_reload;
      logic [7:0] v;
      wr(8'h8A, 8'hFE);
      wr(8'h8C, 8'hA0);
      wr(8'h89, 8'h02);
      wr(8'h8E, 8'h04);
      wr(8'h88, 8'h10);
      wait_sig("reload flag", first_unit_irq, 4);
      wr(8'h88, 8'h20);
      rchk("reload value", 8'h8C, 8'hA0);
      acc(1'b0, 8'h8A, 8'h00, v);
      chk("reloaded low", 8'h01, {7'h00, v >= 8'hA0});
      pulse_ack(1'b0);
      chk("first ack", 8'h00, {7'h00, first_unit_irq});
   endtask : auto_reload
   task automatic gate_run;
      logic [7:0] v;
      wr(8'h8A, 8'h00);
      wr(8'h8C, 8'h00);
      wr(8'h89, 8'h09);
      wr(8'h88, 8'h10);
      repeat (20) @(posedge clk);
      rchk("gate closed", 8'h8A, 8'h00);
      gate_input_a <= 1'b1;
      repeat (20) @(posedge clk);
      acc(1'b0, 8'h8A, 8'h00, v);
      chk("gate open", 8'h01, {7'h00, v != 8'h00});
      gate_input_a <= 1'b0;
      wr(8'h88, 8'h00);
   endtask : gate_run
   task automatic pin_count;
      wr(8'h8A, 8'h00);
      wr(8'h89, 8'h05);
      wr(8'h88, 8'h10);
      count_pin_model_i.pulses(5);
      repeat (4) @(posedge clk);
      rchk("pin edges", 8'h8A, 8'h05);
      wr(8'h88, 8'h00);
   endtask : pin_count
   // Ticks expected in about 96 cycles: /12, /4, /48, and external/8 at 14 ns per oscillator cycle.
   task automatic prescale;
      logic [7:0] v;
      logic [7:0] e[4] = '{8'd8, 8'd24, 8'd2, 8'd4};
      wr(8'h89, 8'h01);
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h8A, 8'h00);
         wr(8'h8E, k[7:0]);
         wr(8'h88, 8'h10);
         repeat (96) @(posedge clk);
         wr(8'h88, 8'h00);
         acc(1'b0, 8'h8A, 8'h00, v);
         chk("prescaled count", 8'h01, {7'h00, v + 8'd1 >= e[k] && v <= e[k] + 8'd1});
      end
   endtask : prescale
   task automatic third_reload;
      wr(8'hCA, 8'h34);
      wr(8'hCB, 8'h12);
      wr(8'hCC, 8'hFE);
      wr(8'hCD, 8'hFF);
      wr(8'h8E, 8'h10);
      wr(8'hC8, 8'h04);
      wait_sig("third overflow", third_irq, 4);
      wr(8'hC8, 8'h80);
      rchk("third reloaded", 8'hCD, 8'h12);
      repeat (10) @(posedge clk);
      chk("flag stands", 8'h01, {7'h00, third_irq});
      wr(8'hC8, 8'h00);
      chk("flag cleared", 8'h00, {7'h00, third_irq});
   endtask : third_reload
   task automatic split_mode;
      wr(8'h8B, 8'h1F);
      wr(8'h8D, 8'hFF);
      wr(8'h8C, 8'hFE);
      wr(8'h8E, 8'h0C);
      wr(8'h89, 8'h03);
      wait_sig("split tick", second_unit_tick, 4);
      chk("split no flag", 8'h00, {7'h00, second_unit_irq});
      wr(8'h88, 8'h40);
      wait_sig("split high flag", second_unit_irq, 4);
   endtask : split_mode
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      reg_rw();
      auto_reload();
      gate_run();
      pin_count();
      prescale();
      third_reload();
      split_mode();
      end_sim();
   end
endmodule : tb
